//--- hdl/mbx_slave.sv
`timescale 1ns/1ps
// Function
// (RULE_01) rejected reply sets top function bit
// (RULE_02) accepted reply echoes function and address; an accepted read returns byte count 0002 in place of the address
// (RULE_03) exception reply carries one error byte
// (RULE_04) unknown function or fault gives code 01
// (RULE_05) bad address or count gives code 02
// (RULE_06) malformed request field gives code 03
// (RULE_07) out of range write gives code 04
// (RULE_08) wrong password check gives code 05
// (RULE_09) bad length or crc gives code 06
// (RULE_10) write to read-only gives code 07
// (RULE_11) run-locked write while running gives 08
// (RULE_12) locked by password gives code 09
// (RULE_13) enforce read-only and write-only per address
// (RULE_14) master sends control commands with write
// (RULE_15) run and pid act only on modbus source
// (RULE_16) decimals carried times ten to n
// (RULE_17) scaled write divides, read multiplies
// (RULE_18) ident word: family high, model low
// (RULE_19) external length and count read-only
// (RULE_20) rtu frames checked by crc-16
module mbx_slave (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_valid,
  input  wire logic              rx_frame_end,
  input  wire logic              drive_running,
  input  wire logic              drive_faulted,
  input  wire logic [15:0]       ext_length_in,
  input  wire logic [15:0]       ext_count_in,
  input  wire logic [15:0]       torque_set_in,
  input  wire logic [15:0]       fault_number_in,
  output logic                   rsp_valid,
  output mbx_pkg::mbx_rsp_t      rsp,
  output logic                   run_cmd_valid,
  output logic [15:0]            run_cmd,
  output logic [15:0]            pid_setpoint,
  output logic [15:0]            wake_delay_s
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one byte step of the reflected crc-16
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mbx_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step

  // times the fieldbus scale, kept to 16 bits
  // same constant as the write divide, so a read returns the written value truncated to whole seconds
  function automatic logic [15:0] times_scale(input logic [15:0] v);
    return 16'(v * mbx_pkg::WAKE_SCALE);
  endfunction : times_scale

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum {MBX_IDLE, MBX_CHECK, MBX_WAIT} mbx_state_t;

  mbx_state_t                state_q;        // sequencer
  logic [7:0]                buf_q [8];      // received bytes by index
  logic [3:0]                cnt_q;          // bytes received
  logic [15:0]               crc_q;          // running crc
  logic [15:0]               crc_rx_q;       // crc over first six bytes
  logic [15:0]               run_src_q;      // run_command_source_select
  logic [15:0]               comm_ch_q;      // comm_run_channel_select
  logic [15:0]               pid_src_q;      // pid_reference_source_select
  logic [15:0]               pwd_q;          // user_password_setting
  logic                      unlocked_q;     // master proved password
  logic [15:0]               wake_q;         // wake_from_sleep_delay in whole seconds
  logic                      rsp_valid_q;    // answer strobe
  mbx_pkg::mbx_rsp_t         rsp_q;          // answer held
  logic                      run_valid_q;    // control command strobe
  logic [15:0]               run_cmd_q;      // control command value
  logic [15:0]               pid_set_q;      // pid setpoint

  mbx_pkg::mbx_req_t         req;            // assembled request
  logic [15:0]               crc_got;        // crc sent by master, low byte first
  logic [7:0]                exc_d;          // exception code, zero when accepted
  logic [15:0]               rd_data_d;      // read result

  assign req     = {buf_q[0], buf_q[1], buf_q[2], buf_q[3], buf_q[4], buf_q[5]};
  assign crc_got = {buf_q[7], buf_q[6]};

  ////////////////////////////////////////////////////////////////////////////
  // byte capture and crc

  // collect bytes of one frame, crc the first six
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q    <= 4'h0;
      crc_q    <= mbx_pkg::CRC_INIT;
      crc_rx_q <= mbx_pkg::CRC_INIT;
      for (int i = 0; i < 8; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (state_q == MBX_CHECK) begin
      cnt_q <= 4'h0;
      crc_q <= mbx_pkg::CRC_INIT;
    end else if (rx_valid && state_q == MBX_IDLE) begin
      if (cnt_q < mbx_pkg::FRAME_LEN) begin
        buf_q[cnt_q[2:0]] <= rx_byte;
      end
      if (cnt_q != 4'hf) begin
        cnt_q <= cnt_q + 4'h1;       // saturates, overlong frame still counted
      end
      crc_q <= crc_step(crc_q, rx_byte);
      // freeze the crc after six bytes, the check bytes must not enter it
      if (cnt_q == 4'(mbx_pkg::REQ_LEN) - 4'h1) begin
        crc_rx_q <= crc_step(crc_q, rx_byte);   // see (RULE_20)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request checking

  // read data per address
  always_comb begin
    rd_data_d = mbx_pkg::ZERO16;
    case (req.addr)
      mbx_pkg::ADDR_RUN_SRC:   rd_data_d = run_src_q;
      mbx_pkg::ADDR_COMM_CH:   rd_data_d = comm_ch_q;
      mbx_pkg::ADDR_PID_SRC:   rd_data_d = pid_src_q;
      mbx_pkg::ADDR_PWD_SET:   rd_data_d = mbx_pkg::ZERO16;  // password never shown
      mbx_pkg::ADDR_WAKE_DLY:  rd_data_d = times_scale(wake_q);   // see (RULE_17)
      mbx_pkg::ADDR_CTRL_CMD:  rd_data_d = run_cmd_q;
      mbx_pkg::ADDR_PID_SET:   rd_data_d = pid_set_q;
      mbx_pkg::ADDR_EXT_LEN:   rd_data_d = ext_length_in;    // see (RULE_19)
      mbx_pkg::ADDR_EXT_CNT:   rd_data_d = ext_count_in;     // see (RULE_19)
      mbx_pkg::ADDR_TRQ_RB:    rd_data_d = torque_set_in;
      mbx_pkg::ADDR_IDENT:     rd_data_d = {mbx_pkg::IDENT_FAMILY, mbx_pkg::IDENT_MODEL}; // see (RULE_18)
      mbx_pkg::ADDR_FAULT:     rd_data_d = fault_number_in;
      default:                 rd_data_d = mbx_pkg::ZERO16;
    endcase
  end

  // classify the request, first failing check wins
  always_comb begin
    logic known;
    logic ro;
    logic wo;
    logic runlock;
    known   = 1'b0;
    ro      = 1'b0;
    wo      = 1'b0;
    runlock = 1'b0;
    exc_d   = 8'h00;
    case (req.addr)
      mbx_pkg::ADDR_RUN_SRC, mbx_pkg::ADDR_COMM_CH,
      mbx_pkg::ADDR_PID_SRC, mbx_pkg::ADDR_PWD_SET: begin
        known   = 1'b1;
        runlock = 1'b1;              // source and password held while running
      end
      mbx_pkg::ADDR_WAKE_DLY, mbx_pkg::ADDR_CTRL_CMD,
      mbx_pkg::ADDR_PID_SET: begin
        known = 1'b1;
      end
      mbx_pkg::ADDR_PWD_CHECK: begin
        known = 1'b1;
        wo    = 1'b1;
      end
      mbx_pkg::ADDR_EXT_LEN, mbx_pkg::ADDR_EXT_CNT, mbx_pkg::ADDR_TRQ_RB,
      mbx_pkg::ADDR_IDENT, mbx_pkg::ADDR_FAULT: begin
        known = 1'b1;
        ro    = 1'b1;
      end
      default: begin
        known = 1'b0;
      end
    endcase
    if (cnt_q != mbx_pkg::FRAME_LEN || crc_got != crc_rx_q) begin
      exc_d = mbx_pkg::EXC_FRAME;                                  // see (RULE_09) (RULE_20)
    end else if ((req.func != mbx_pkg::FC_READ && req.func != mbx_pkg::FC_WRITE)
                 || drive_faulted) begin
      exc_d = mbx_pkg::EXC_BAD_CMD;                                // see (RULE_04)
    end else if (req.func == mbx_pkg::FC_READ && req.data != mbx_pkg::READ_QTY_ONE) begin
      exc_d = mbx_pkg::EXC_BAD_ADDR;                               // see (RULE_05)
    end else if (!known) begin
      exc_d = mbx_pkg::EXC_BAD_ADDR;                               // see (RULE_05)
    end else if (pwd_q != mbx_pkg::ZERO16 && !unlocked_q
                 && req.addr != mbx_pkg::ADDR_PWD_CHECK) begin
      exc_d = mbx_pkg::EXC_LOCKED;                                 // see (RULE_12)
    end else if (req.func == mbx_pkg::FC_READ && wo) begin
      exc_d = mbx_pkg::EXC_BAD_ADDR;                               // see (RULE_13)
    end else if (req.func == mbx_pkg::FC_WRITE && ro) begin
      exc_d = mbx_pkg::EXC_RO;                                     // see (RULE_10) (RULE_13)
    end else if (req.func == mbx_pkg::FC_WRITE && runlock && drive_running) begin
      exc_d = mbx_pkg::EXC_RUNLOCK;                                // see (RULE_11)
    end else if (req.func == mbx_pkg::FC_WRITE) begin
      case (req.addr)
        mbx_pkg::ADDR_PWD_CHECK:
          if (req.data != pwd_q) exc_d = mbx_pkg::EXC_PWD;        // see (RULE_08)
        mbx_pkg::ADDR_RUN_SRC:
          if (req.data > mbx_pkg::RUN_SRC_MAX) exc_d = mbx_pkg::EXC_OP_FAIL; // see (RULE_07)
        mbx_pkg::ADDR_COMM_CH:
          if (req.data > mbx_pkg::COMM_CH_MAX) exc_d = mbx_pkg::EXC_OP_FAIL; // see (RULE_07)
        mbx_pkg::ADDR_PID_SRC:
          if (req.data > mbx_pkg::PID_SRC_MAX) exc_d = mbx_pkg::EXC_OP_FAIL; // see (RULE_07)
        mbx_pkg::ADDR_WAKE_DLY:
          if (req.data > mbx_pkg::WAKE_MAX_BUS) exc_d = mbx_pkg::EXC_OP_FAIL; // see (RULE_07)
        mbx_pkg::ADDR_PID_SET:
          if (req.data > mbx_pkg::PID_SET_MAX) exc_d = mbx_pkg::EXC_OP_FAIL; // see (RULE_07)
        mbx_pkg::ADDR_CTRL_CMD:
          if (req.data < mbx_pkg::CMD_MIN || req.data > mbx_pkg::CMD_MAX) begin
            exc_d = mbx_pkg::EXC_BAD_DATA;                         // see (RULE_06)
          end
        default: exc_d = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // idle until frame end, check one cycle, wait for frame end to drop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= MBX_IDLE;
    end else begin
      case (state_q)
        MBX_IDLE:  if (rx_frame_end) state_q <= MBX_CHECK;
        MBX_CHECK: state_q <= MBX_WAIT;
        MBX_WAIT:  if (!rx_frame_end) state_q <= MBX_IDLE;
        default:   state_q <= MBX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response build

  // one-cycle answer strobe with held answer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else begin
      rsp_valid_q <= (state_q == MBX_CHECK);
      if (state_q == MBX_CHECK) begin
        if (exc_d != 8'h00) begin
          rsp_q.func   <= req.func | mbx_pkg::FC_EXC_BIT;         // see (RULE_01)
          rsp_q.word_a <= mbx_pkg::ZERO16;
          rsp_q.word_b <= mbx_pkg::ZERO16;
          rsp_q.exc    <= exc_d;                                  // see (RULE_03)
          rsp_q.is_exc <= 1'b1;
        end else begin
          rsp_q.func   <= req.func;                               // see (RULE_02)
          rsp_q.word_a <= (req.func == mbx_pkg::FC_READ) ? 16'h0002 : req.addr; // see (RULE_02)
          rsp_q.word_b <= (req.func == mbx_pkg::FC_READ) ? rd_data_d : req.data;
          rsp_q.exc    <= 8'h00;
          rsp_q.is_exc <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter store

  logic wr_ok;   // accepted write this cycle
  assign wr_ok = (state_q == MBX_CHECK) && exc_d == 8'h00 && req.func == mbx_pkg::FC_WRITE;

  // settings and password
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_src_q  <= mbx_pkg::RUN_SRC_RST;
      comm_ch_q  <= mbx_pkg::COMM_CH_MODBUS;
      pid_src_q  <= mbx_pkg::ZERO16;
      pwd_q      <= mbx_pkg::ZERO16;
      unlocked_q <= 1'b0;
      wake_q     <= mbx_pkg::ZERO16;
    end else if (wr_ok) begin
      case (req.addr)
        mbx_pkg::ADDR_RUN_SRC:   run_src_q  <= req.data;
        mbx_pkg::ADDR_COMM_CH:   comm_ch_q  <= req.data;
        mbx_pkg::ADDR_PID_SRC:   pid_src_q  <= req.data;
        mbx_pkg::ADDR_PWD_SET:   pwd_q      <= req.data;
        mbx_pkg::ADDR_PWD_CHECK: unlocked_q <= 1'b1;
        mbx_pkg::ADDR_WAKE_DLY:  wake_q     <= req.data / mbx_pkg::WAKE_SCALE; // see (RULE_16) (RULE_17)
        default:                 wake_q     <= wake_q;
      endcase
    end
  end

  // control command and pid setpoint, gated by the selected source
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      run_valid_q <= 1'b0;
      run_cmd_q   <= mbx_pkg::ZERO16;
      pid_set_q   <= mbx_pkg::ZERO16;
    end else begin
      run_valid_q <= 1'b0;
      if (wr_ok && req.addr == mbx_pkg::ADDR_CTRL_CMD && run_src_q == mbx_pkg::RUN_SRC_COMM
          && comm_ch_q == mbx_pkg::COMM_CH_MODBUS) begin
        run_valid_q <= 1'b1;                                      // see (RULE_14) (RULE_15)
        run_cmd_q   <= req.data;
      end
      if (wr_ok && req.addr == mbx_pkg::ADDR_PID_SET
          && pid_src_q == mbx_pkg::PID_SRC_MODBUS) begin
        pid_set_q <= req.data;                                    // see (RULE_15)
      end
    end
  end

  assign rsp_valid     = rsp_valid_q;
  assign rsp           = rsp_q;
  assign run_cmd_valid = run_valid_q;
  assign run_cmd       = run_cmd_q;
  assign pid_setpoint  = pid_set_q;
  assign wake_delay_s  = wake_q;

endmodule : mbx_slave

//--- hdl/mbx_pkg.sv
package mbx_pkg;

  // function codes and exception marking
  localparam logic [7:0] FC_READ      = 8'h03;    // read holding registers
  localparam logic [7:0] FC_WRITE     = 8'h06;    // write single register
  localparam logic [7:0] FC_EXC_BIT   = 8'h80;    // top bit marks an exception reply

  // exception codes
  localparam logic [7:0] EXC_BAD_CMD  = 8'h01;    // invalid command
  localparam logic [7:0] EXC_BAD_ADDR = 8'h02;    // invalid data address
  localparam logic [7:0] EXC_BAD_DATA = 8'h03;    // invalid data field
  localparam logic [7:0] EXC_OP_FAIL  = 8'h04;    // value out of range or conflicting
  localparam logic [7:0] EXC_PWD      = 8'h05;    // password mismatch
  localparam logic [7:0] EXC_FRAME    = 8'h06;    // length or crc error
  localparam logic [7:0] EXC_RO       = 8'h07;    // write to read-only item
  localparam logic [7:0] EXC_RUNLOCK  = 8'h08;    // locked while running
  localparam logic [7:0] EXC_LOCKED   = 8'h09;    // system locked by password

  // register addresses
  localparam logic [15:0] ADDR_RUN_SRC   = 16'h0001; // run command source select
  localparam logic [15:0] ADDR_COMM_CH   = 16'h0002; // comm run channel select
  localparam logic [15:0] ADDR_PWD_SET   = 16'h0700; // user password setting
  localparam logic [15:0] ADDR_PID_SRC   = 16'h0900; // pid reference source select
  localparam logic [15:0] ADDR_WAKE_DLY  = 16'h0114; // wake from sleep delay, scale 10
  localparam logic [15:0] ADDR_CTRL_CMD  = 16'h2000; // communication control command
  localparam logic [15:0] ADDR_PID_SET   = 16'h2002; // pid setpoint via comms
  localparam logic [15:0] ADDR_PWD_CHECK = 16'h2010; // password verification, write only
  localparam logic [15:0] ADDR_EXT_LEN   = 16'h3013; // external_length_value
  localparam logic [15:0] ADDR_EXT_CNT   = 16'h3014; // external_count_value
  localparam logic [15:0] ADDR_TRQ_RB    = 16'h3015; // torque_setpoint_readback
  localparam logic [15:0] ADDR_IDENT     = 16'h3016; // product_ident_word
  localparam logic [15:0] ADDR_FAULT     = 16'h5000; // active_fault_number

  // source selections
  localparam logic [15:0] RUN_SRC_COMM   = 16'h0002; // run source is communication
  localparam logic [15:0] RUN_SRC_MAX    = 16'h0002; // highest legal run source
  localparam logic [15:0] COMM_CH_MODBUS = 16'h0000; // comm channel is modbus
  localparam logic [15:0] COMM_CH_MAX    = 16'h0003; // highest legal channel
  localparam logic [15:0] PID_SRC_MODBUS = 16'h0006; // pid reference from modbus
  localparam logic [15:0] PID_SRC_MAX    = 16'h0007; // highest legal pid source
  localparam logic [15:0] CMD_MIN        = 16'h0001; // lowest control command
  localparam logic [15:0] CMD_MAX        = 16'h0008; // highest control command
  localparam logic [15:0] PID_SET_MAX    = 16'h03e8; // pid setpoint limit, 100.0 %

  // scaled parameter: wake delay stored in seconds, bus carries tenths
  localparam logic [15:0] WAKE_SCALE     = 16'h000a; // ten to the power one
  localparam logic [15:0] WAKE_MAX_BUS   = 16'h8ca0; // 3600.0 s on the bus

  // reset values
  localparam logic [15:0] RUN_SRC_RST    = 16'h0000; // keypad
  localparam logic [15:0] ZERO16         = 16'h0000; // cleared word

  // identification, values arbitrary
  localparam logic [7:0]  IDENT_FAMILY   = 8'h5a;  // arbitrary family code
  localparam logic [7:0]  IDENT_MODEL    = 8'h3c;  // arbitrary model code

  // frame checking
  localparam logic [15:0] CRC_INIT       = 16'hffff; // crc-16 seed
  localparam logic [15:0] CRC_POLY       = 16'ha001; // reflected polynomial
  localparam logic [2:0]  REQ_LEN        = 3'h6;     // bytes before crc
  localparam logic [3:0]  FRAME_LEN      = 4'h8;     // whole request length
  localparam logic [2:0]  EXC_LEN        = 3'h3;     // exception reply before crc
  localparam logic [15:0] READ_QTY_ONE   = 16'h0001; // one word per read

  // request as received
  typedef struct packed {
    logic [7:0]  slave;   // station address
    logic [7:0]  func;    // function code
    logic [15:0] addr;    // register address
    logic [15:0] data;    // quantity or write data
  } mbx_req_t;

  // answer handed back to the framer
  typedef struct packed {
    logic [7:0]  func;    // echoed or marked function code
    logic [15:0] word_a;  // address echo, or byte count in low byte
    logic [15:0] word_b;  // data echo or read data
    logic [7:0]  exc;     // exception code
    logic        is_exc;  // exception reply
  } mbx_rsp_t;

endpackage : mbx_pkg

//--- testbench/mbx_master_model.sv
`timescale 1ns/1ps
// upper computer: sends one request frame and waits for the answer
module mbx_master_model (
  input  wire logic       sys_clk,
  input  wire logic       rsp_valid,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            rx_frame_end
);
  logic [7:0] frm [0:7];  // frame bytes, crc low byte first
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_frame_end = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // mode 0 good frame, 1 corrupted check value, 2 frame one byte short
  task automatic send(input logic [7:0] func, input logic [15:0] addr,
                      input logic [15:0] data, input int mode, output logic answered);
    logic [15:0] crc;
    frm[0] = 8'h01;
    frm[1] = func;
    frm[2] = addr[15:8];
    frm[3] = addr[7:0];
    frm[4] = data[15:8];
    frm[5] = data[7:0];
    crc = mbx_pkg::CRC_INIT;
    for (int i = 0; i < 6; i++) begin
      crc = crc ^ {8'h00, frm[i]};
      for (int k = 0; k < 8; k++) begin
        crc = crc[0] ? ((crc >> 1) ^ mbx_pkg::CRC_POLY) : (crc >> 1);
      end
    end
    frm[6] = crc[7:0] ^ ((mode == 1) ? 8'h01 : 8'h00);
    frm[7] = crc[15:8];
    for (int i = 0; i < ((mode == 2) ? 7 : 8); i++) begin
      @(negedge sys_clk);
      rx_byte = frm[i];
      rx_valid = 1'b1;
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_byte = ~rx_byte;  // released line shows no stale byte
    rx_frame_end = 1'b1;
    answered = 1'b0;
    for (int c = 0; c < 16 && !answered; c++) begin
      @(negedge sys_clk);
      answered = (rsp_valid === 1'b1);
    end
    @(negedge sys_clk);
    rx_frame_end = 1'b0;
    @(negedge sys_clk);
  endtask : send
endmodule : mbx_master_model

//--- testbench/mbx_slave_monitor.sv
`timescale 1ns/1ps
// watches the answer side of the request checker
module mbx_slave_monitor (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              rx_frame_end,
  input  wire logic              drive_faulted,
  input  wire logic              rsp_valid,
  input  wire mbx_pkg::mbx_rsp_t rsp,
  input  wire logic              run_cmd_valid,
  input  wire logic [15:0]       run_cmd,
  input  wire logic [15:0]       wake_delay_s
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_frame_seen;
    $rose(rx_frame_end);
  endsequence
  sequence s_answer;
    ##[1:3] rsp_valid;
  endsequence
  sequence s_exc_out;
    rsp_valid && rsp.is_exc;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_answer_time: assert property (s_frame_seen |-> s_answer)
    else $error("no answer after frame end");
  a_exc_top_bit: assert property (s_exc_out |-> rsp.func[7])
    else $error("exception function code lacks top bit");
  a_exc_one_byte: assert property (s_exc_out |-> rsp.exc inside {[8'h01:8'h09]}
    && rsp.word_a == 16'h0000 && rsp.word_b == 16'h0000) else $error("bad exception body");
  a_normal_echo: assert property (rsp_valid && !rsp.is_exc |-> rsp.exc == 8'h00
    && (rsp.func == mbx_pkg::FC_READ || rsp.func == mbx_pkg::FC_WRITE))
    else $error("normal answer function code altered");
  a_read_count: assert property (rsp_valid && !rsp.is_exc
    && rsp.func == mbx_pkg::FC_READ |-> rsp.word_a == 16'h0002)
    else $error("read byte count wrong");
  a_fault_cmd: assert property (rsp_valid && $past(drive_faulted)
    && rsp.exc != mbx_pkg::EXC_FRAME |-> rsp.is_exc && rsp.exc == mbx_pkg::EXC_BAD_CMD)
    else $error("faulted drive accepted a request");
  a_run_gate: assert property (run_cmd_valid |-> rsp_valid && !rsp.is_exc
    && rsp.word_a == mbx_pkg::ADDR_CTRL_CMD && run_cmd == rsp.word_b)
    else $error("run command not tied to accepted write");
  a_run_hold: assert property (!run_cmd_valid |-> $stable(run_cmd))
    else $error("run command changed without pulse");
  a_rsp_hold: assert property (!rsp_valid |-> $stable(rsp))
    else $error("answer changed between strobes");
  a_wake_range: assert property (wake_delay_s <= 16'h0e10)
    else $error("stored wake delay above limit");
endmodule : mbx_slave_monitor

bind mbx_slave mbx_slave_monitor u_mon (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .rx_frame_end(rx_frame_end),
  .drive_faulted(drive_faulted), .rsp_valid(rsp_valid), .rsp(rsp),
  .run_cmd_valid(run_cmd_valid), .run_cmd(run_cmd), .wake_delay_s(wake_delay_s));

//--- testbench/tb_mbx_slave.sv
`timescale 1ns/1ps
// request sequences against the slave through the master model
module tb_mbx_slave;
  localparam logic [7:0] RD = mbx_pkg::FC_READ;   // read opcode
  localparam logic [7:0] WR = mbx_pkg::FC_WRITE;  // write opcode
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [7:0]        rx_byte;
  logic              rx_valid, rx_frame_end, rsp_valid, run_cmd_valid, answered;
  logic              drive_running = 1'b0;
  logic              drive_faulted = 1'b0;
  logic [15:0]       run_cmd, pid_setpoint, wake_delay_s;
  logic              run_seen = 1'b0;  // gated command pulse observed
  mbx_pkg::mbx_rsp_t rsp;
  int                errors = 0;
  int                num_checks = 0;
  int                cycles = 0;
  always #4 sys_clk = ~sys_clk;
  mbx_master_model master (.sys_clk(sys_clk), .rsp_valid(rsp_valid), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_frame_end(rx_frame_end));
  mbx_slave dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_frame_end(rx_frame_end), .drive_running(drive_running), .drive_faulted(drive_faulted),
    .ext_length_in(16'hffff), .ext_count_in(16'h0000), .torque_set_in(16'h0bb8),
    .fault_number_in(16'h0017), .rsp_valid(rsp_valid), .rsp(rsp), .run_cmd_valid(run_cmd_valid),
    .run_cmd(run_cmd), .pid_setpoint(pid_setpoint), .wake_delay_s(wake_delay_s));
  ////////////////////////////////////////////////////////////////////////////////
  // cycle ceiling and pulse capture
  always @(posedge sys_clk) begin
    cycles++;
    if (run_cmd_valid === 1'b1) run_seen <= 1'b1;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done;
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk_word
  task automatic chk_rsp(input mbx_pkg::mbx_rsp_t exp);
    num_checks++;
    if (answered !== 1'b1 || rsp !== exp) begin
      errors++;
      $display("unexpected answer: expected %h seen %h", exp, rsp);
    end
  endtask : chk_rsp
  // one request, answer predicted from the request and the expected code
  task automatic op(input logic [7:0] func, input logic [15:0] addr, input logic [15:0] data,
                    input logic [7:0] exc, input logic [15:0] rdv, input int mode);
    mbx_pkg::mbx_rsp_t e;
    master.send(func, addr, data, mode, answered);
    if (exc != 8'h00) e = {func | mbx_pkg::FC_EXC_BIT, 16'h0000, 16'h0000, exc, 1'b1};
    else if (func == RD) e = {func, 16'h0002, rdv, 8'h00, 1'b0};
    else e = {func, addr, data, 8'h00, 1'b0};
    chk_rsp(e);
  endtask : op
  task automatic rd(input logic [15:0] addr, input logic [15:0] val, input logic [7:0] exc);
    op(RD, addr, 16'h0001, exc, val, 0);
  endtask : rd
  task automatic wr(input logic [15:0] addr, input logic [15:0] data, input logic [7:0] exc);
    op(WR, addr, data, exc, 16'h0000, 0);
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    rd(mbx_pkg::ADDR_EXT_LEN, 16'hffff, 8'h00);
    rd(mbx_pkg::ADDR_EXT_CNT, 16'h0000, 8'h00);
    rd(mbx_pkg::ADDR_TRQ_RB, 16'h0bb8, 8'h00);
    rd(mbx_pkg::ADDR_IDENT, {mbx_pkg::IDENT_FAMILY, mbx_pkg::IDENT_MODEL}, 8'h00);
    rd(mbx_pkg::ADDR_FAULT, 16'h0017, 8'h00);
    wr(mbx_pkg::ADDR_EXT_CNT, 16'h0001, mbx_pkg::EXC_RO);
    wr(mbx_pkg::ADDR_IDENT, 16'h0000, mbx_pkg::EXC_RO);
    op(8'h10, mbx_pkg::ADDR_IDENT, 16'h0001, mbx_pkg::EXC_BAD_CMD, 16'h0000, 0);
    op(RD, mbx_pkg::ADDR_IDENT, 16'h0002, mbx_pkg::EXC_BAD_ADDR, 16'h0000, 0);
    rd(16'h4000, 16'h0000, mbx_pkg::EXC_BAD_ADDR);
    rd(mbx_pkg::ADDR_PWD_CHECK, 16'h0000, mbx_pkg::EXC_BAD_ADDR);
    op(RD, mbx_pkg::ADDR_IDENT, 16'h0001, mbx_pkg::EXC_FRAME, 16'h0000, 1);
    op(RD, mbx_pkg::ADDR_IDENT, 16'h0001, mbx_pkg::EXC_FRAME, 16'h0000, 2);
    drive_faulted = 1'b1;
    rd(mbx_pkg::ADDR_IDENT, 16'h0000, mbx_pkg::EXC_BAD_CMD);
    wr(mbx_pkg::ADDR_WAKE_DLY, 16'h0001, mbx_pkg::EXC_BAD_CMD);
    drive_faulted = 1'b0;
    wr(mbx_pkg::ADDR_RUN_SRC, 16'h0003, mbx_pkg::EXC_OP_FAIL);
    wr(mbx_pkg::ADDR_CTRL_CMD, 16'h0009, mbx_pkg::EXC_BAD_DATA);
    wr(mbx_pkg::ADDR_CTRL_CMD, 16'h0000, mbx_pkg::EXC_BAD_DATA);
    wr(mbx_pkg::ADDR_CTRL_CMD, 16'h0001, 8'h00);
    chk_word("run pulse", 16'h0000, {15'h0000, run_seen});
    wr(mbx_pkg::ADDR_RUN_SRC, mbx_pkg::RUN_SRC_COMM, 8'h00);
    wr(mbx_pkg::ADDR_COMM_CH, mbx_pkg::COMM_CH_MODBUS, 8'h00);
    wr(mbx_pkg::ADDR_CTRL_CMD, 16'h0005, 8'h00);
    chk_word("run pulse", 16'h0001, {15'h0000, run_seen});
    chk_word("run_cmd", 16'h0005, run_cmd);
    wr(mbx_pkg::ADDR_PID_SET, 16'h01f4, 8'h00);
    chk_word("pid_setpoint", 16'h0000, pid_setpoint);
    wr(mbx_pkg::ADDR_PID_SRC, mbx_pkg::PID_SRC_MODBUS, 8'h00);
    wr(mbx_pkg::ADDR_PID_SET, 16'h01f4, 8'h00);
    chk_word("pid_setpoint", 16'h01f4, pid_setpoint);
    wr(mbx_pkg::ADDR_PID_SET, 16'h03e9, mbx_pkg::EXC_OP_FAIL);
    wr(mbx_pkg::ADDR_WAKE_DLY, 16'h0032, 8'h00);
    chk_word("wake_delay_s", 16'h0005, wake_delay_s);
    rd(mbx_pkg::ADDR_WAKE_DLY, 16'h0032, 8'h00);
    wr(mbx_pkg::ADDR_WAKE_DLY, 16'h8ca1, mbx_pkg::EXC_OP_FAIL);
    wr(mbx_pkg::ADDR_WAKE_DLY, 16'h8ca0, 8'h00);
    chk_word("wake_delay_s", 16'h0e10, wake_delay_s);
    drive_running = 1'b1;
    wr(mbx_pkg::ADDR_RUN_SRC, 16'h0000, mbx_pkg::EXC_RUNLOCK);
    wr(mbx_pkg::ADDR_WAKE_DLY, 16'h0064, 8'h00);
    drive_running = 1'b0;
    wr(mbx_pkg::ADDR_PWD_SET, 16'h1234, 8'h00);
    rd(mbx_pkg::ADDR_IDENT, 16'h0000, mbx_pkg::EXC_LOCKED);
    wr(mbx_pkg::ADDR_PWD_CHECK, 16'h1111, mbx_pkg::EXC_PWD);
    wr(mbx_pkg::ADDR_PWD_CHECK, 16'h1234, 8'h00);
    rd(mbx_pkg::ADDR_IDENT, {mbx_pkg::IDENT_FAMILY, mbx_pkg::IDENT_MODEL}, 8'h00);
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk_word("wake_delay_s", 16'h0000, wake_delay_s);
    chk_word("pid_setpoint", 16'h0000, pid_setpoint);
    test_done();
  end
endmodule : tb_mbx_slave
